/* File: bench/qstx_host_model.sv */
// host logic model: character clocks, characters and parity
`timescale 1ns/10ps
`default_nettype none

module qstx_host_model (
    input  wire logic       pclk,
    input  wire logic [3:0] per_a,
    input  wire logic [3:0] per_b,
    input  wire logic [9:0] chr,
    input  wire logic       bad_par,
    output logic      [39:0] tx_char_in,
    output logic      [3:0]  tx_odd_parity_in,
    output logic      [3:0]  per_channel_tx_clock
);
    logic [3:0] ca = 4'h0;
    logic [3:0] cb = 4'h0;

    // free running counters set each clock period
    always_ff @(posedge pclk) begin
        ca <= (ca >= per_a - 4'h1) ? 4'h0 : ca + 4'h1;
        cb <= (cb >= per_b - 4'h1) ? 4'h0 : cb + 4'h1;
    end

    // same character on all channels, odd parity unless spoiled
    assign per_channel_tx_clock = {{3{cb < per_b / 4'h2}}, ca < per_a / 4'h2};
    assign tx_char_in           = {4{chr}};
    assign tx_odd_parity_in     = {4{~^chr ^ bad_par}};

endmodule // qstx_host_model
`default_nettype wire

/* File: bench/qstx_top_asserts.sv */
// concurrent checks on the quad transmit path ports
`timescale 1ns/10ps
`default_nettype none

module qstx_top_asserts #(
    parameter int PB_DEPTH = 4
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        phase_buffer_init_n,
    input wire logic [7:0]  channel_enable_bus,
    input wire logic        out_enable_latch_open,
    input wire logic        device_reset_n,
    input wire logic [3:0]  serial_out_pair,
    input wire logic [3:0]  serial_out_oe,
    input wire logic [3:0]  tx_phase_error
);
    qstx_pkg::qstx_ctrl_s ctrl_q;
    logic [3:0]           rst_hist;
    logic [5:0]           init_age;
    logic [5:0]           ctrl_age;
    logic                 quiet;
    logic                 acc;

    // access phase and device reset long released
    assign acc   = psel && penable;
    assign quiet = device_reset_n && (&rst_hist);

    // mirror of the control register and its age
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= '0;
            ctrl_age <= 6'h00;
        end else if (acc && pwrite && paddr == qstx_pkg::OFS_CTRL) begin
            ctrl_q   <= pwdata[8:0];
            ctrl_age <= 6'h00;
        end else if (ctrl_age != 6'h3f) begin
            ctrl_age <= ctrl_age + 6'h01;
        end
    end

    // device reset history and time since init was low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_hist <= 4'h0;
            init_age <= 6'h00;
        end else begin
            rst_hist <= {rst_hist[2:0], device_reset_n};
            init_age <= !phase_buffer_init_n ? 6'h00 : init_age + {5'h0, init_age != 6'h3f};
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_slverr;
        acc |-> pslverr == (paddr != qstx_pkg::OFS_CTRL && paddr != qstx_pkg::OFS_STATUS);
    endproperty
    a_slverr: assert property (p_slverr) else $error("slave error flag wrong");

    property p_rd_ctrl;
        acc && !pwrite && paddr == qstx_pkg::OFS_CTRL |-> prdata == {23'h0, ctrl_q};
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read back wrong");

    property p_oe_follow;
        (out_enable_latch_open && quiet && $stable(channel_enable_bus)) [*6] |->
            serial_out_oe == {channel_enable_bus[6], channel_enable_bus[4],
                              channel_enable_bus[2], channel_enable_bus[0]};
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("open latch not followed");

    property p_oe_hold;
        (!out_enable_latch_open && quiet) [*6] |=> $stable(serial_out_oe);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("closed latch changed");

    property p_oe_reset;
        !device_reset_n [*6] |-> serial_out_oe == 4'h0;
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("drivers on in reset");

    property p_perr_reset;
        !device_reset_n [*6] |-> tx_phase_error == 4'h0;
    endproperty
    a_perr_reset: assert property (p_perr_reset) else $error("error kept in reset");

    property p_loop;
        quiet |-> ((ctrl_q.loop & $past(ctrl_q.loop) & $past(ctrl_q.loop, 2))
                   & ~serial_out_pair) == 4'h0;
    endproperty
    a_loop: assert property (p_loop) else $error("loopback output not one");

    property p_sticky;
        init_age >= 6'd40 && ctrl_age >= 6'd40 && quiet && !(acc && pwrite) |=>
            (~tx_phase_error & $past(tx_phase_error)) == 4'h0;
    endproperty
    a_sticky: assert property (p_sticky) else $error("phase error dropped");

endmodule // qstx_top_asserts
`default_nettype wire

/* File: bench/quad_serdes_tx_path_tb.sv */
// self-checking bench for the quad transmit path
`timescale 1ns/10ps
`default_nettype none

module quad_serdes_tx_path_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [39:0] tx_char_in;
    logic [3:0]  tx_odd_parity_in;
    logic [3:0]  per_channel_tx_clock;
    logic        phase_buffer_init_n = 1'b1;
    logic [7:0]  channel_enable_bus = 8'h00;
    logic        selftest_latch_open = 1'b0;
    logic        out_enable_latch_open = 1'b0;
    logic        device_reset_n = 1'b0;
    logic [3:0]  serial_out_pair;
    logic [3:0]  serial_out_oe;
    logic [3:0]  tx_phase_error;
    logic [3:0]  per_a = 4'ha;
    logic [3:0]  per_b = 4'ha;
    logic [9:0]  chr = 10'h000;
    logic        bad = 1'b0;
    logic [32:0] q[$];
    logic [19:0] s;
    qstx_pkg::qstx_ctrl_s cw;
    int          n_fail = 0;
    int          checked = 0;
    int          seed;

    always #2.5 pclk = ~pclk;

    qstx_top qstx_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .tx_char_in, .tx_odd_parity_in, .per_channel_tx_clock,
        .phase_buffer_init_n, .channel_enable_bus, .selftest_latch_open,
        .out_enable_latch_open, .device_reset_n, .serial_out_pair, .serial_out_oe,
        .tx_phase_error);

    qstx_host_model qstx_host_model_inst (.pclk, .per_a, .per_b, .chr, .bad_par(bad),
        .tx_char_in, .tx_odd_parity_in, .per_channel_tx_clock);

    task automatic close_out();
        $display("checks %0d fails %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_fail++;
            close_out();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic apb_rd(input logic [11:0] a, input logic [32:0] exp);
        q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic ctrl_wr();
        apb(1'b1, qstx_pkg::OFS_CTRL, {23'h0, cw});
    endtask

    // read results compared in order of issue
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, q.pop_front());
    end

    function automatic logic has(input logic [19:0] v, input logic [9:0] c);
        for (int k = 0; k < 10; k++) if (v[k +: 10] === c) return 1'b1;
        return 1'b0;
    endfunction

    task automatic grab(input int ch);
        for (int i = 0; i < 20; i++) begin
            @(negedge pclk);
            s[i] = serial_out_pair[ch];
        end
    endtask

    task automatic see(input int ch, input logic [9:0] c);
        grab(ch);
        check({32'h0, has(s, c)}, 33'h1);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic init_pulse();
        @(posedge pclk);
        phase_buffer_init_n <= 1'b0;
        wait_clk(30);
        phase_buffer_init_n <= 1'b1;
        wait_clk(60);
    endtask

    // main sequence
    initial begin
        seed = $urandom(32'hdc7b2926);
        cw = '0;
        wait_clk(20);
        presetn <= 1'b1;
        device_reset_n <= 1'b1;
        wait_clk(8);
        apb_rd(qstx_pkg::OFS_CTRL, 33'h0);
        apb_rd(qstx_pkg::OFS_STATUS, 33'h0);
        apb_rd(12'h008, {1'b1, 32'h0});
        apb(1'b1, qstx_pkg::OFS_STATUS, 32'hffffffff);
        apb_rd(qstx_pkg::OFS_STATUS, 33'h0);
        channel_enable_bus <= 8'h14;
        out_enable_latch_open <= 1'b1;
        wait_clk(10);
        check({29'h0, serial_out_oe}, 33'h6);
        channel_enable_bus <= 8'h55;
        wait_clk(10);
        out_enable_latch_open <= 1'b0;
        wait_clk(10);
        channel_enable_bus <= 8'h00;
        wait_clk(10);
        check({29'h0, serial_out_oe}, 33'hf);
        apb_rd(qstx_pkg::OFS_STATUS, 33'h5500);
        chr <= 10'h00b;
        wait_clk(60);
        see(0, 10'h00b);
        for (int i = 0; i < 6; i++) begin
            cw.par = 2'(i % 3);
            ctrl_wr();
            chr <= 10'($urandom());
            bad <= 1'(i >= 3);
            wait_clk(60);
            see(0, (i >= 3 && i % 3 != 0) ? qstx_pkg::BAD_CHAR : chr);
        end
        cw.par = qstx_pkg::SEL_LOW;
        cw.half = 1'b1;
        ctrl_wr();
        apb_rd(qstx_pkg::OFS_CTRL, {29'h0, 4'h4});
        init_pulse();
        see(0, chr);
        cw.half = 1'b0;
        cw.src = qstx_pkg::SEL_MID;
        ctrl_wr();
        per_b <= 4'h9;
        init_pulse();
        for (int n = 0; n < 3000 && tx_phase_error[1] !== 1'b1; n++) @(posedge pclk);
        if (tx_phase_error[1] !== 1'b1) begin
            n_fail++;
            close_out();
        end
        wait_clk(200);
        check({29'h0, tx_phase_error}, 33'he);
        see(1, qstx_pkg::BAD_CHAR);
        see(0, chr);
        cw.src = qstx_pkg::SEL_HIGH;
        ctrl_wr();
        init_pulse();
        wait_clk(300);
        check({29'h0, tx_phase_error}, 33'h0);
        see(1, chr);
        cw.src = qstx_pkg::SEL_LOW;
        ctrl_wr();
        channel_enable_bus <= 8'hfd;
        selftest_latch_open <= 1'b1;
        wait_clk(10);
        selftest_latch_open <= 1'b0;
        wait_clk(4);
        channel_enable_bus <= 8'hff;
        wait_clk(60);
        apb_rd(qstx_pkg::OFS_STATUS, 33'h5510);
        grab(0);
        check({32'h0, s[9:0] !== s[19:10]}, 33'h1);
        see(1, chr);
        device_reset_n <= 1'b0;
        wait_clk(10);
        device_reset_n <= 1'b1;
        wait_clk(10);
        apb_rd(qstx_pkg::OFS_STATUS, 33'h0);
        channel_enable_bus <= 8'h55;
        out_enable_latch_open <= 1'b1;
        wait_clk(10);
        out_enable_latch_open <= 1'b0;
        cw.loop = 4'h5;
        ctrl_wr();
        wait_clk(40);
        grab(0);
        check({13'h0, s}, {13'h0, 20'hfffff});
        see(1, chr);
        close_out();
    end

endmodule // quad_serdes_tx_path_tb

bind qstx_top qstx_top_asserts #(.PB_DEPTH(PB_DEPTH)) qstx_top_asserts_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .phase_buffer_init_n,
    .channel_enable_bus, .out_enable_latch_open, .device_reset_n, .serial_out_pair,
    .serial_out_oe, .tx_phase_error);
`default_nettype wire

/* File: rtl/qstx_pkg.sv */
// constants, types and helper functions for the quad transmit path
package qstx_pkg;

    localparam int CHANNELS = 4;
    localparam int CHAR_W   = 10;

    // timing: one character on the line per reference character period
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CHAR_TIME_PS  = 50000;
    localparam int CHAR_CYCLES   = CHAR_TIME_PS / CLK_PERIOD_PS;

    // apb register map
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;

    // three-level select encodings
    localparam logic [1:0] SEL_LOW  = 2'h0;
    localparam logic [1:0] SEL_MID  = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;

    // fixed characters and seeds
    localparam logic [CHAR_W-1:0] BAD_CHAR  = 10'h278;
    localparam logic [8:0]        LFSR_SEED = 9'h1ff;

    // reset values
    localparam logic [8:0] CTRL_RST     = 9'h000;
    localparam logic [7:0] OE_LATCH_RST = 8'h00;
    localparam logic [3:0] BIST_EN_RST  = 4'h0;

    // pointer gap set at buffer initialisation
    localparam int PB_NOMINAL = 2;

    // control register layout, bit 0 upward: src, half, par, loop
    typedef struct packed {
        logic [3:0] loop;
        logic [1:0] par;
        logic       half;
        logic [1:0] src;
    } qstx_ctrl_s;

    // character plus its parity bit as carried through the buffer
    typedef struct packed {
        logic              par;
        logic [CHAR_W-1:0] data;
    } qstx_char_s;

    typedef enum logic [1:0] {
        PB_RUN,
        PB_LOW1,
        PB_ARMED
    } qstx_init_e;

    // odd parity over character and parity bit
    function automatic logic odd_ok(input qstx_char_s c);
        return ^{c.par, c.data};
    endfunction

    // one step of the 9-bit generator, x^9 + x^5 + 1
    function automatic logic [8:0] lfsr_step(input logic [8:0] s);
        return {s[7:0], s[8] ^ s[4]};
    endfunction

endpackage

/* File: rtl/qstx_top.sv */
// four-channel transmit path: capture, phase buffer, parity, self-test, serializer
`timescale 1ns/10ps
`default_nettype none

module qstx_top #(
    parameter int PB_DEPTH = 4
) (
    input  wire logic                                      pclk,
    input  wire logic                                      presetn,
    input  wire logic                                      psel,
    input  wire logic                                      penable,
    input  wire logic                                      pwrite,
    input  wire logic [11:0]                               paddr,
    input  wire logic [31:0]                               pwdata,
    output logic      [31:0]                               prdata,
    output logic                                           pready,
    output logic                                           pslverr,
    input  wire logic [qstx_pkg::CHANNELS*qstx_pkg::CHAR_W-1:0] tx_char_in,
    input  wire logic [qstx_pkg::CHANNELS-1:0]             tx_odd_parity_in,
    input  wire logic [qstx_pkg::CHANNELS-1:0]             per_channel_tx_clock,
    input  wire logic                                      phase_buffer_init_n,
    input  wire logic [7:0]                                channel_enable_bus,
    input  wire logic                                      selftest_latch_open,
    input  wire logic                                      out_enable_latch_open,
    input  wire logic                                      device_reset_n,
    output logic      [qstx_pkg::CHANNELS-1:0]             serial_out_pair,
    output logic      [qstx_pkg::CHANNELS-1:0]             serial_out_oe,
    output logic      [qstx_pkg::CHANNELS-1:0]             tx_phase_error
);

    localparam int NCH  = qstx_pkg::CHANNELS;
    localparam int CW   = qstx_pkg::CHAR_W;
    localparam int PW   = $clog2(PB_DEPTH);
    // pin bits: chars, parity, clocks, four controls, bus
    localparam int SYNW = NCH * CW + 2 * NCH + 4 + 8;
    localparam int CNTW = $clog2(qstx_pkg::CHAR_CYCLES);

    // pin synchroniser stages
    logic [SYNW-1:0] sync1;
    logic [SYNW-1:0] sync2;

    // synchronised pin views
    logic [NCH*CW-1:0] s_chars;
    logic [NCH-1:0]    s_par;
    logic [NCH-1:0]    s_clk;
    logic [NCH-1:0]    s_clk_d;
    logic [NCH-1:0]    clk_rise;
    logic              s_init_n;
    logic [7:0]        s_bus;
    logic              s_bist_open;
    logic              s_oe_open;
    logic              s_dev_rst_n;

    // configuration and latches
    qstx_pkg::qstx_ctrl_s ctrl;
    logic [7:0]           oe_latch;
    logic [NCH-1:0]       bist_en;

    // character timing and buffer initialisation
    logic [CNTW-1:0]      char_cnt;
    logic                 tick;
    qstx_pkg::qstx_init_e init_state;
    logic                 init_done;

    // mode decode shared by all channels
    logic par_on;
    logic bypass;

    // clock pins are plain data here, edges lag by three
    // two-flop synchroniser on every pin input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {tx_char_in, tx_odd_parity_in, per_channel_tx_clock,
                      phase_buffer_init_n, selftest_latch_open,
                      out_enable_latch_open, device_reset_n, channel_enable_bus};
            sync2 <= sync1;
        end
    end

    // only the second stage is read
    assign {s_chars, s_par, s_clk, s_init_n, s_bist_open, s_oe_open,
            s_dev_rst_n, s_bus} = sync2;

    // input clock edge detect on synchronised levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_clk_d <= '0;
        end else begin
            s_clk_d <= s_clk;
        end
    end

    // one-cycle strobe per input clock rise
    assign clk_rise = s_clk & ~s_clk_d;

    // reference character tick from the bit-rate clock
    // device reset parks the count, tick stays high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            char_cnt <= '0;
        end else if (!s_dev_rst_n) begin
            char_cnt <= '0;
        end else if (char_cnt == CNTW'(qstx_pkg::CHAR_CYCLES - 1)) begin
            char_cnt <= '0;
        end else begin
            char_cnt <= char_cnt + 1'b1;
        end
    end

    // first bit time of each character
    assign tick = (char_cnt == '0);

    // buffer init: low on two ticks arms, release sets phase
    // a lone low tick falls back to run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_state <= qstx_pkg::PB_RUN;
        end else if (!s_dev_rst_n) begin
            init_state <= qstx_pkg::PB_RUN;
        end else if (tick) begin
            case (init_state)
                qstx_pkg::PB_RUN: begin
                    if (!s_init_n) begin
                        init_state <= qstx_pkg::PB_LOW1;
                    end
                end
                qstx_pkg::PB_LOW1: begin
                    if (s_init_n) begin
                        init_state <= qstx_pkg::PB_RUN;
                    end else begin
                        init_state <= qstx_pkg::PB_ARMED;
                    end
                end
                qstx_pkg::PB_ARMED: begin
                    if (s_init_n) begin
                        init_state <= qstx_pkg::PB_RUN;
                    end
                end
                default: begin
                    init_state <= qstx_pkg::PB_RUN;
                end
            endcase
        end
    end

    assign init_done = tick && s_init_n && (init_state == qstx_pkg::PB_ARMED);

    // self-test enable latch, transparent while open
    // odd bits are transmit, low means self-test on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bist_en <= qstx_pkg::BIST_EN_RST;
        end else if (!s_dev_rst_n) begin
            bist_en <= qstx_pkg::BIST_EN_RST;
        end else if (s_bist_open) begin
            for (int i = 0; i < NCH; i++) begin
                bist_en[i] <= ~s_bus[2*i+1];
            end
        end
    end

    // output enable latch holds all eight bits
    // even bits gate drivers, odd ones kept for read-back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_latch <= qstx_pkg::OE_LATCH_RST;
        end else if (!s_dev_rst_n) begin
            oe_latch <= qstx_pkg::OE_LATCH_RST;
        end else if (s_oe_open) begin
            oe_latch <= s_bus;
        end
    end

    // apb: always ready, errors on unmapped addresses
    // no wait states: one setup, one access cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable &&
                     (paddr != qstx_pkg::OFS_CTRL) && (paddr != qstx_pkg::OFS_STATUS);

    // control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= qstx_pkg::CTRL_RST;
        end else if (psel && penable && pwrite && paddr == qstx_pkg::OFS_CTRL) begin
            ctrl <= pwdata[8:0];
        end
    end

    // read data registered in the setup cycle
    // keeps prdata steady through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == qstx_pkg::OFS_CTRL) begin
                prdata <= {23'h000000, ctrl};
            end else if (paddr == qstx_pkg::OFS_STATUS) begin
                prdata <= {16'h0000, oe_latch, bist_en, tx_phase_error};
            end else begin
                prdata <= '0;
            end
        end
    end

    // parity on at middle or high
    assign par_on = (ctrl.par != qstx_pkg::SEL_LOW);
    // reference clock at full rate skips the buffer
    assign bypass = (ctrl.src == qstx_pkg::SEL_LOW) && !ctrl.half;

    // one path per channel, channel A clock also shared
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        qstx_pkg::qstx_char_s in_reg;
        qstx_pkg::qstx_char_s pb_mem [PB_DEPTH];
        qstx_pkg::qstx_char_s pb_out;
        qstx_pkg::qstx_char_s src_char;
        logic [PW:0]          wr_ptr;
        logic [PW:0]          rd_ptr;
        logic [PW:0]          occ;
        logic                 cap_en;
        logic                 pb_wr;
        logic                 pb_rd;
        logic                 pb_fault;
        logic                 perr;
        logic [8:0]           lfsr;
        logic [CW-1:0]        next_char;
        logic [CW-1:0]        shifter;
        logic                 pwr_on;

        // driver enable doubles as channel power switch
        assign pwr_on = oe_latch[2*g];

        // capture strobe per clock source
        always_comb begin
            case (ctrl.src)
                qstx_pkg::SEL_LOW: cap_en = tick;
                qstx_pkg::SEL_MID: cap_en = clk_rise[g];
                default:           cap_en = clk_rise[0];
            endcase
        end

        // input register
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                in_reg <= '0;
            end else if (cap_en && !bist_en[g]) begin
                in_reg.data <= s_chars[g*CW +: CW];
                in_reg.par  <= par_on ? s_par[g] : 1'b0;
            end
        end

        // buffer write one cycle after capture, read on each tick
        // the delay lets the input register settle first
        logic cap_d;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cap_d <= 1'b0;
            end else begin
                cap_d <= cap_en && !bist_en[g];
            end
        end

        assign pb_wr    = cap_d && !bypass;
        assign pb_rd    = tick && !bypass;
        assign occ      = wr_ptr - rd_ptr;
        // drift beyond two characters shows as over or underrun
        assign pb_fault = (pb_wr && !pb_rd && occ == (PW+1)'(PB_DEPTH)) ||
                          (pb_rd && !pb_wr && occ == '0);
        assign pb_out   = pb_mem[rd_ptr[PW-1:0]];

        // storage needs no reset, pointers decide validity
        always_ff @(posedge pclk) begin
            if (pb_wr) begin
                pb_mem[wr_ptr[PW-1:0]] <= in_reg;
            end
        end

        // pointers reset to nominal gap at init
        // extra pointer bit keeps full and empty apart
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                wr_ptr <= (PW+1)'(qstx_pkg::PB_NOMINAL);
                rd_ptr <= '0;
            end else if (!s_dev_rst_n || init_done) begin
                wr_ptr <= (PW+1)'(qstx_pkg::PB_NOMINAL);
                rd_ptr <= '0;
            end else begin
                if (pb_wr) begin
                    wr_ptr <= wr_ptr + 1'b1;
                end
                if (pb_rd) begin
                    rd_ptr <= rd_ptr + 1'b1;
                end
            end
        end

        // sticky phase error, set wins over re-init
        // meaningless in bypass, so entering it clears
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                perr <= 1'b0;
            end else if (pb_fault) begin
                perr <= 1'b1;
            end else if (!s_dev_rst_n || init_done || bypass) begin
                perr <= 1'b0;
            end
        end

        assign tx_phase_error[g] = perr;

        // self-test generator from fixed seed
        // held at seed while off, each run starts alike
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lfsr <= qstx_pkg::LFSR_SEED;
            end else if (!bist_en[g] || !s_dev_rst_n) begin
                lfsr <= qstx_pkg::LFSR_SEED;
            end else if (tick) begin
                lfsr <= qstx_pkg::lfsr_step(lfsr);
            end
        end

        // bypass takes the input register for low latency
        assign src_char = bypass ? in_reg : pb_out;

        // character selection priority: self-test, phase error, parity
        // self-test first, parallel inputs are ignored then
        always_comb begin
            if (bist_en[g]) begin
                next_char = {lfsr[0] ^ lfsr[8], lfsr};
            end else if (perr) begin
                next_char = qstx_pkg::BAD_CHAR;
            end else if (par_on && !qstx_pkg::odd_ok(src_char)) begin
                next_char = qstx_pkg::BAD_CHAR;
            end else begin
                next_char = src_char.data;
            end
        end

        // serializer, lsb first, idle while driver powered down
        // zero fill leaves an idle line low
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                shifter <= '0;
            end else if (!pwr_on || !s_dev_rst_n) begin
                shifter <= '0;
            end else if (tick) begin
                shifter <= next_char;
            end else begin
                shifter <= {1'b0, shifter[CW-1:1]};
            end
        end

        // driver output and enable
        // loopback one keeps test data off the line
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                serial_out_pair[g] <= 1'b0;
                serial_out_oe[g]   <= 1'b0;
            end else begin
                serial_out_pair[g] <= ctrl.loop[g] ? 1'b1 : shifter[0];
                serial_out_oe[g]   <= pwr_on;
            end
        end
    end

endmodule // qstx_top

`default_nettype wire
